// ===== arith_logic_exec.sv
`timescale 1ns/1ns
`default_nettype none
module arith_logic_exec (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              start,
  input  wire logic [15:0]       instr_word,
  input  wire exec_pkg::exec_op_t mem_op,
  input  wire logic              long_form,
  input  wire logic [15:0]       eff_addr,
  input  wire logic [5:0]        indirect_depth,
  input  wire logic              protect_fault,
  input  wire logic [3:0]        sense_sw,
  input  wire logic              run_button,
  input  wire logic              step_mode,
  input  wire logic              int_pending,
  input  wire logic              console_load,
  input  wire logic [15:0]       console_a,
  input  wire logic [15:0]       console_b,
  input  wire logic [15:0]       console_x,
  input  wire logic [15:0]       console_p,
  input  wire logic [15:0]       mem_rdata,
  input  wire logic              mem_ack,
  output logic                   ready_r,
  output logic                   done_r,
  output logic                   halted_r,
  output logic                   trap_r,
  output logic                   int_grant_r,
  output logic [15:0]            acc_a_r,
  output logic [15:0]            acc_b_r,
  output logic [15:0]            idx_x_r,
  output logic [15:0]            pc_r,
  output logic                   ovf_r,
  output logic                   mem_req_r,
  output logic                   mem_we_r,
  output logic [15:0]            mem_addr_r,
  output logic [15:0]            mem_wdata_r
);
  import exec_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  exec_state_t state_r;              // Sequencer state.
  exec_op_t    op_r;                 // Latched command.
  logic [15:0] word_r;               // Latched instruction word.
  logic [15:0] ea_r;                 // Latched effective address.
  logic        long_r;               // Long form of the instruction.
  logic [15:0] op1_r, op2_r;         // Operand words at e and e+1.
  logic [9:0]  elapsed_r;            // Tenths of a cycle since start.
  logic [7:0]  div_r;                // Divider for the tenth tick.
  logic        tick;                 // One-cycle tenth enable.
  logic [3:0]  sw_s1_r, sw_s2_r;     // Sense switch synchroniser.
  logic [2:0]  run_s_r;              // Run button sync plus edge stage.
  logic [1:0]  step_s_r;             // Step mode synchroniser.
  logic        run_rise;             // Run button pressed.
  logic        commit;               // Instruction ends this cycle.
  logic [15:0] plen;                 // Length of the instruction.

  // Results of the current instruction, applied on commit.
  logic [15:0] res_a, res_b, res_x, res_p, wdata;
  logic        res_ovf, is_halt, is_trap, two_rd, do_rd, do_wr;
  logic [9:0]  need;

  // Floating point, double, copy and skip working values.
  logic signed [22:0] fma, fmb;
  logic [7:0]         fea, feb;
  logic signed [31:0] dsum;
  logic [15:0]        cp_src;
  logic               skip_hit;

  // ----------------------------------------------------------------
  // Normalization
  // ----------------------------------------------------------------
  // Brings a wide two's complement mantissa into 23-bit normal form,
  // where the bit below the sign differs from the sign. Exponent
  // overflow gives signed full scale; underflow collapses to zero,
  // which is a trade for area over gradual underflow.
  function automatic void fnorm(input logic signed [25:0] s_in,
                                input logic signed [10:0] e_in,
                                output logic [15:0] w1,
                                output logic [15:0] w2,
                                output logic ov,
                                output logic [4:0] cnt);
    logic signed [25:0] s;
    logic signed [10:0] x;
    s   = s_in;
    x   = e_in;
    cnt = 5'h00;
    for (int i = 0; i < 3; i++) begin
      if (s[25:22] != {4{s[25]}}) begin
        s = s >>> 1;
        x = x + 11'sh001;
      end
    end
    for (int i = 0; i < 22; i++) begin
      if (s != 26'sh0 && s[22] == s[21]) begin
        s   = s <<< 1;
        x   = x - 11'sh001;
        cnt = cnt + 5'h01;
      end
    end
    ov = (x > 11'sh0ff);
    if (ov) begin
      w1 = s[25] ? 16'h8000 : 16'h7fff;
      w2 = s[25] ? 16'h00ff : 16'h7fff;
    end else if (s == 26'sh0 || x < 11'sh000) begin
      w1 = 16'h0000;
      w2 = 16'h0000;
    end else begin
      w1 = s[22:7];
      w2 = {1'b0, s[6:0], x[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers and timing
  // ----------------------------------------------------------------
  // Console pins and switches are asynchronous to ref_clk.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sw_s1_r  <= 4'h0;
      sw_s2_r  <= 4'h0;
      run_s_r  <= 3'h0;
      step_s_r <= 2'h0;
    end else begin
      sw_s1_r  <= sense_sw;
      sw_s2_r  <= sw_s1_r;
      run_s_r  <= {run_s_r[1:0], run_button};
      step_s_r <= {step_s_r[0], step_mode};
    end
  end

  assign run_rise = run_s_r[1] & ~run_s_r[2];

  // The tenth tick restarts with every instruction so that the
  // instruction time is counted from acceptance.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_r     <= 8'h00;
      elapsed_r <= 10'h000;
    end else if (start && state_r == S_IDLE) begin
      div_r     <= 8'h00;
      elapsed_r <= 10'h000;
    end else if (tick) begin
      div_r <= 8'h00;
      if (elapsed_r != 10'h3ff) begin
        elapsed_r <= elapsed_r + 10'h001;
      end
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  assign tick   = (div_r == 8'(CLK_PER_TENTH - 1));
  assign commit = (state_r == S_WAIT) && (elapsed_r >= need);
  assign plen   = long_r ? 16'h0002 : 16'h0001;

  // ----------------------------------------------------------------
  // Execution results
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] fa1, fa2, fm1, fm2, fd1, fd2;
    logic        fao, fmo, fdo;
    logic [4:0]  fac, fmc, fdc, al;
    logic signed [25:0] sa, sb;
    logic [7:0]  big, d;
    logic signed [45:0] prod;
    logic signed [44:0] quo;
    fa1 = 16'h0; fa2 = 16'h0; fm1 = 16'h0; fm2 = 16'h0;
    fd1 = 16'h0; fd2 = 16'h0; fao = 1'b0; fmo = 1'b0; fdo = 1'b0;
    fac = 5'h0; fmc = 5'h0; fdc = 5'h0; al = 5'h0; big = 8'h0; d = 8'h0;
    sa = 26'sh0; sb = 26'sh0; prod = 46'sh0; quo = 45'sh0;
    // Unpack single floats: sign and mantissa, then offset exponent.
    // float layout
    fma = $signed({acc_a_r, acc_b_r[14:8]});
    fea = acc_b_r[7:0];
    fmb = $signed({op1_r, op2_r[14:8]});
    feb = op2_r[7:0];
    // Align the smaller exponent; a zero operand takes no part.
    // zero normalizes
    sa = 26'(fma);
    sb = (op_r == OP_FLOAT_SUBTRACT) ? -26'(fmb) : 26'(fmb);
    d  = (fea >= feb) ? fea - feb : feb - fea;
    al = (d > 8'(ALIGN_MAX)) ? ALIGN_MAX : d[4:0];
    if (fma == 23'sh0) begin
      big = feb;
      al  = 5'h00;
    end else if (fmb == 23'sh0) begin
      big = fea;
      al  = 5'h00;
    end else if (fea >= feb) begin
      big = fea;
      sb  = (d > 8'h19) ? 26'sh0 : sb >>> d;
    end else begin
      big = feb;
      sa  = (d > 8'h19) ? 26'sh0 : sa >>> d;
    end
    fnorm(sa + sb, $signed({3'h0, big}), fa1, fa2, fao, fac);
    prod = fma * fmb;
    fnorm(26'($signed(prod[45:22])),
          $signed({3'h0, fea}) + $signed({3'h0, feb}) - 11'sh080,
          fm1, fm2, fmo, fmc);
    // The divisor is forced non-zero so the divider never sees zero.
    quo = $signed({fma, 22'h0}) / ((fmb == 23'sh0) ? 23'sh1 : fmb);
    fnorm(quo[25:0],
          $signed({3'h0, fea}) - $signed({3'h0, feb}) + 11'sh080,
          fd1, fd2, fdo, fdc);
    if (fmb == 23'sh0 || quo[44:25] != {20{quo[25]}}) begin
      fdo = 1'b1;
      fd1 = (fma[22] ^ fmb[22]) ? 16'h8000 : 16'h7fff;
      fd2 = (fma[22] ^ fmb[22]) ? 16'h00ff : 16'h7fff;
    end
    // Double operands: A carries sign and high bits, B bit 15 is zero.
    // double layout
    dsum = (op_r == OP_DOUBLE_SUBTRACT)
         ? 32'($signed({acc_a_r, acc_b_r[14:0]})) - 32'($signed({op1_r, op2_r[14:0]}))
         : 32'($signed({acc_a_r, acc_b_r[14:0]})) + 32'($signed({op1_r, op2_r[14:0]}));
    // Copy source: 1 selects A, 2 B, 3 X, 0 a zero word.
    case (word_r[1:0])
      2'h1:    cp_src = acc_a_r;
      2'h2:    cp_src = acc_b_r;
      2'h3:    cp_src = idx_x_r;
      default: cp_src = 16'h0000;
    endcase
    if (word_r[CP_NEG]) begin
      cp_src = 16'h0000 - cp_src;
    end
    skip_hit = (|(word_r[3:0] & sw_s2_r))
             | (word_r[SK_OVF] & ovf_r)
             | (word_r[SK_AP] & ~acc_a_r[15] & (acc_a_r != 16'h0))
             | (word_r[SK_AZ] & (acc_a_r == 16'h0))
             | (word_r[SK_BZ] & (acc_b_r == 16'h0))
             | (word_r[SK_XZ] & (idx_x_r == 16'h0));
    // Defaults: nothing but P moves on.
    res_a = acc_a_r; res_b = acc_b_r; res_x = idx_x_r;
    res_p = pc_r + plen; res_ovf = ovf_r; wdata = 16'h0000;
    is_halt = 1'b0; is_trap = 1'b0; need = T_ONE;
    two_rd = 1'b0; do_rd = 1'b1; do_wr = 1'b0;
    case (op_r)
      OP_DOUBLE_ADD, OP_DOUBLE_SUBTRACT: begin
        two_rd  = 1'b1;
        res_a   = dsum[30:15];
        res_b   = {1'b0, dsum[14:0]};
        res_ovf = ovf_r | (dsum[31:30] != {2{dsum[30]}});
        need    = (op_r == OP_DOUBLE_ADD) ? T_DOUBLE_ADD : T_DOUBLE_SUBTRACT;
      end
      OP_FLOAT_ADD, OP_FLOAT_SUBTRACT: begin
        two_rd = 1'b1;
        res_a = fa1; res_b = fa2; res_ovf = ovf_r | fao;
        need = T_FLOAT_ADD_MIN + 10'(al) * T_ONE + 10'(fac) * T_NORM_STEP;
      end
      OP_FLOAT_MULTIPLY: begin
        two_rd = 1'b1;
        res_a = fm1; res_b = fm2; res_ovf = ovf_r | fmo; need = T_FLOAT_MULTIPLY;
      end
      OP_FLOAT_DIVIDE: begin
        two_rd = 1'b1;
        res_a = fd1; res_b = fd2; res_ovf = ovf_r | fdo; need = T_FLOAT_DIVIDE;
      end
      OP_INC, OP_DEC: begin
        do_wr = 1'b1;
        wdata = (op_r == OP_INC) ? op1_r + 16'h0001 : op1_r - 16'h0001;
        need  = T_INCDEC;
      end
      OP_XOR, OP_AND, OP_OR: begin
        res_a = (op_r == OP_XOR) ? acc_a_r ^ op1_r :
                (op_r == OP_AND) ? acc_a_r & op1_r : acc_a_r | op1_r;
        need  = long_r ? T_LONG : T_SHORT;
      end
      OP_CALL: begin
        do_rd = 1'b0; do_wr = 1'b1;
        wdata = pc_r + plen;
        res_p = ea_r + 16'h0001;
        need  = long_r ? T_LONG : T_SHORT;
      end
      default: begin
        do_rd = 1'b0;
        if (word_r == HALT_WORD) begin
          is_halt = 1'b1;
        end else if (word_r >= TRAP_LO && word_r <= TRAP_HI) begin
          is_trap = 1'b1;
          res_p   = TRAP_OP_LOC;
        end else if (word_r[15:9] == CLS_COPY) begin
          need = (word_r == NOP_WORD) ? T_NOP : T_ONE;
          if ((!word_r[CP_OVS] || ovf_r) && (!word_r[CP_OVC] || !ovf_r)) begin
            if (word_r[CP_DA]) res_a = cp_src;
            if (word_r[CP_DB]) res_b = cp_src;
            if (word_r[CP_DX]) res_x = cp_src;
          end
        end else if (word_r[15:9] == CLS_SKANY || word_r[15:9] == CLS_SKALL) begin
          if ((word_r[15:9] == CLS_SKANY) == (skip_hit || word_r[8:0] == 9'h000)) begin
            res_p = pc_r + 16'h0002;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and memory port
  // ----------------------------------------------------------------
  // Reads, then the write-back, then the wait for the full time.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      op_r <= OP_DECODE; word_r <= 16'h0; ea_r <= 16'h0; long_r <= 1'b0;
      op1_r <= 16'h0; op2_r <= 16'h0;
      mem_req_r <= 1'b0; mem_we_r <= 1'b0;
      mem_addr_r <= 16'h0; mem_wdata_r <= 16'h0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (start) begin
            op_r <= mem_op; word_r <= instr_word;
            ea_r <= eff_addr; long_r <= long_form;
            if (indirect_depth > MAX_INDIRECT || protect_fault) begin
              state_r <= S_IDLE;
            end else if (mem_op == OP_CALL) begin
              mem_req_r <= 1'b1; mem_we_r <= 1'b1; mem_addr_r <= eff_addr;
              mem_wdata_r <= pc_r + (long_form ? 16'h0002 : 16'h0001);
              state_r <= S_WR;
            end else if (mem_op != OP_DECODE) begin
              mem_req_r <= 1'b1; mem_we_r <= 1'b0; mem_addr_r <= eff_addr;
              state_r <= S_RD0;
            end else begin
              state_r <= S_WAIT;
            end
          end
        end
        S_RD0: if (mem_ack) begin
          op1_r <= mem_rdata;
          if (two_rd) begin
            mem_addr_r <= ea_r + 16'h0001;
            state_r <= S_RD1;
          end else if (do_wr) begin
            mem_we_r <= 1'b1;
            mem_wdata_r <= (op_r == OP_INC) ? mem_rdata + 16'h0001
                                            : mem_rdata - 16'h0001;
            state_r <= S_WR;
          end else begin
            mem_req_r <= 1'b0;
            state_r <= S_WAIT;
          end
        end
        S_RD1: if (mem_ack) begin
          op2_r <= mem_rdata; mem_req_r <= 1'b0; state_r <= S_WAIT;
        end
        S_WR: if (mem_ack) begin
          mem_req_r <= 1'b0; mem_we_r <= 1'b0; state_r <= S_WAIT;
        end
        S_WAIT: begin
          if (commit && (is_halt || (step_s_r[1] && op_r != OP_CALL))) begin
            state_r <= S_HALT;
          end else if (commit) begin
            state_r <= S_IDLE;
          end
        end
        S_HALT: if (run_rise) state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  // The console may load registers only while nothing is executing.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_a_r <= 16'h0; acc_b_r <= 16'h0; idx_x_r <= 16'h0; pc_r <= 16'h0;
      ovf_r <= 1'b0;
    end else if (console_load && (state_r == S_IDLE || state_r == S_HALT)
                 && !(start && state_r == S_IDLE)) begin
      acc_a_r <= console_a; acc_b_r <= console_b;
      idx_x_r <= console_x; pc_r <= console_p;
    end else if (state_r == S_IDLE && start &&
                 (indirect_depth > MAX_INDIRECT || protect_fault)) begin
      pc_r <= TRAP_ADDR_LOC;
    end else if (commit) begin
      acc_a_r <= res_a; acc_b_r <= res_b; idx_x_r <= res_x;
      pc_r <= res_p; ovf_r <= res_ovf;
    end
  end

  // Status and event outputs.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ready_r <= 1'b1; done_r <= 1'b0; halted_r <= 1'b0;
      trap_r <= 1'b0; int_grant_r <= 1'b0;
    end else begin
      ready_r  <= (state_r == S_IDLE && !start) || (state_r == S_WAIT && commit
                  && !is_halt && !(step_s_r[1] && op_r != OP_CALL));
      done_r   <= commit;
      halted_r <= (state_r == S_HALT && !run_rise) ||
                  (commit && (is_halt || (step_s_r[1] && op_r != OP_CALL)));
      trap_r   <= (commit && is_trap) || (state_r == S_IDLE && start &&
                  (indirect_depth > MAX_INDIRECT || protect_fault));
      int_grant_r <= commit && int_pending && op_r != OP_CALL;
    end
  end

endmodule
`default_nettype wire

// ===== arith_logic_exec_properties.sv
`timescale 1ns/1ns
`default_nettype none
module exec_checker
  import exec_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        start,
  input wire logic        long_form,
  input wire logic        ready_r,
  input wire logic        done_r,
  input wire logic        halted_r,
  input wire logic        trap_r,
  input wire logic        ovf_r,
  input wire logic        mem_req_r,
  input wire logic        mem_we_r,
  input wire logic        mem_ack,
  input wire exec_op_t    mem_op,
  input wire logic [15:0] pc_r,
  input wire logic [15:0] mem_addr_r,
  input wire logic [15:0] mem_wdata_r
);
  logic [11:0] cyc_r;  // Clocks since the instruction was taken.
  logic [11:0] lo_r;   // Least legal time in clocks, zero when not checked.
  logic        busy_r; // An instruction is in flight.
  exec_op_t    op_r;   // Command of that instruction.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Timing is counted from the taking edge, so memory waits only add clocks.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      cyc_r  <= 12'h000;
      lo_r   <= 12'h000;
      op_r   <= OP_DECODE;
    end else if (start && ready_r) begin
      busy_r <= 1'b1;
      cyc_r  <= 12'h000;
      op_r   <= mem_op;
      case (mem_op)
        OP_DOUBLE_ADD:                 lo_r <= 12'h0fa;
        OP_DOUBLE_SUBTRACT:                 lo_r <= 12'h12c;
        OP_INC, OP_DEC:          lo_r <= 12'h0c8;
        OP_XOR, OP_AND, OP_OR,
        OP_CALL:                 lo_r <= long_form ? 12'h096 : 12'h064;
        default:                 lo_r <= 12'h000;
      endcase
    end else if (done_r) begin
      busy_r <= 1'b0;
    end else begin
      cyc_r <= cyc_r + 12'h001;
    end
  end
  chk_done_pulse: assert property (done_r |=> !done_r)
    else $error("done pulse too long");
  chk_trap_target: assert property (trap_r |-> ##[0:1] (pc_r == 16'h0003 || pc_r == 16'h0002))
    else $error("trap went to a wrong location");
  chk_req_hold: assert property (mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r)
    && $stable(mem_we_r) && $stable(mem_wdata_r))
    else $error("memory request changed before ack");
  chk_start_taken: assert property (start && ready_r |=> !ready_r)
    else $error("start not taken");
  chk_ovf_kept: assert property (busy_r && (op_r == OP_INC || op_r == OP_DEC) |-> $stable(ovf_r))
    else $error("overflow changed by increment or decrement");
  chk_op_time: assert property (done_r && busy_r && lo_r != 12'h000
    |-> cyc_r >= lo_r && cyc_r <= lo_r + 12'h028)
    else $error("instruction time out of range");
  chk_write_last: assert property (mem_req_r && mem_we_r && mem_ack |=> !mem_req_r)
    else $error("request after final write");
  chk_halt_quiet: assert property (halted_r && $past(halted_r) |-> !mem_req_r && !done_r)
    else $error("activity while halted");
endmodule
bind arith_logic_exec exec_checker u_chk (.*);
`default_nettype wire

// ===== core_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  lat,
  output logic      [15:0] rdata,
  output logic             ack
);
  logic [15:0] mem [64];  // Small core; the address wraps at 64 words.
  logic [1:0]  wait_r;    // Cycles waited on the current access.
  initial begin
    ack    = 1'b0;
    rdata  = 16'h0000;
    wait_r = 2'h0;
  end
  // Data lines toggle when neither requested nor answering, so stale data is never trusted.
  always @(posedge ref_clk) begin
    ack <= 1'b0;
    if (req && !ack && wait_r < lat) begin
      wait_r <= wait_r + 2'h1;
    end else if (req && !ack) begin
      wait_r <= 2'h0;
      ack    <= 1'b1;
      if (we) mem[addr[5:0]] <= wdata;
      else rdata <= mem[addr[5:0]];
    end else if (!ack) begin
      rdata <= ~rdata;
    end
  end
endmodule
`default_nettype wire

// ===== exec_pkg.sv
package exec_pkg;

  // ----------------------------------------------------------------
  // Clock and machine-cycle timing
  // ----------------------------------------------------------------
  // Instruction times are kept in tenths of a machine cycle, so that
  // fractional figures such as 1.6 cycles stay exact.
  localparam int CLK_NS        = 20;    // Period of ref_clk.
  localparam int MCYC_NS       = 1000;  // Length of one machine cycle.
  localparam int TENTHS        = 10;    // Timer ticks per machine cycle.
  localparam int CLK_PER_TENTH = MCYC_NS / (TENTHS * CLK_NS);

  // Instruction times in tenths of a machine cycle.
  localparam logic [9:0] T_DOUBLE_ADD      = 10'h032;  // 5 cycles.
  localparam logic [9:0] T_DOUBLE_SUBTRACT      = 10'h03c;  // 6 cycles.
  localparam logic [9:0] T_FLOAT_ADD_MIN  = 10'h06e;  // 11 cycles.
  localparam logic [9:0] T_FLOAT_MULTIPLY      = 10'h258;  // 60 cycles.
  localparam logic [9:0] T_FLOAT_DIVIDE      = 10'h2bc;  // 70 cycles.
  localparam logic [9:0] T_INCDEC    = 10'h028;  // 4 cycles.
  localparam logic [9:0] T_LONG      = 10'h01e;  // 3 cycles.
  localparam logic [9:0] T_SHORT     = 10'h014;  // 2 cycles.
  localparam logic [9:0] T_NOP       = 10'h010;  // 1.6 cycles.
  localparam logic [9:0] T_ONE       = 10'h00a;  // 1 cycle.
  localparam logic [9:0] T_NORM_STEP = 10'h002;  // Per normalize shift.
  localparam logic [4:0] ALIGN_MAX   = 5'h11;    // 28 - 11 cycles.

  // ----------------------------------------------------------------
  // Fixed locations and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] TRAP_OP_LOC   = 16'h0003;
  localparam logic [15:0] TRAP_ADDR_LOC = 16'h0002;
  localparam logic [5:0]  MAX_INDIRECT  = 6'h1f;

  // ----------------------------------------------------------------
  // Instruction word encodings and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] HALT_WORD = 16'h0000;
  localparam logic [15:0] NOP_WORD  = 16'h0400;
  localparam logic [15:0] TRAP_LO   = 16'h0108;
  localparam logic [15:0] TRAP_HI   = 16'h01ff;
  localparam logic [6:0]  CLS_COPY  = 7'h02;
  localparam logic [6:0]  CLS_SKANY = 7'h04;
  localparam logic [6:0]  CLS_SKALL = 7'h05;
  localparam int CP_NEG = 2;  // Negate bit; source in bits 1:0.
  localparam int CP_DA  = 3;  // Destination A.
  localparam int CP_DX  = 4;  // Destination X.
  localparam int CP_DB  = 5;  // Destination B.
  localparam int CP_OVS = 7;  // Execute only with overflow set.
  localparam int CP_OVC = 6;  // Execute only with overflow clear.
  localparam int SK_OVF = 4;  // Sense switches sit in bits 3:0.
  localparam int SK_AP  = 5;
  localparam int SK_AZ  = 6;
  localparam int SK_BZ  = 7;
  localparam int SK_XZ  = 8;

  // ----------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_DECODE, OP_DOUBLE_ADD, OP_DOUBLE_SUBTRACT, OP_FLOAT_ADD, OP_FLOAT_SUBTRACT, OP_FLOAT_MULTIPLY, OP_FLOAT_DIVIDE,
    OP_INC, OP_DEC, OP_XOR, OP_AND, OP_OR, OP_CALL
  } exec_op_t;

  typedef enum logic [2:0] {
    S_IDLE, S_RD0, S_RD1, S_WR, S_WAIT, S_HALT
  } exec_state_t;

endpackage

// ===== test_arith_logic_exec.sv
`timescale 1ns/1ns
`default_nettype none
module test_arith_logic_exec;
  import exec_pkg::*;
  logic ref_clk, rstn, start, long_form, protect_fault, run_button, step_mode, int_pending;
  logic console_load, mem_ack, ready_r, done_r, halted_r, trap_r, int_grant_r, ovf_r;
  logic mem_req_r, mem_we_r;
  logic [15:0] instr_word, eff_addr, console_a, console_b, console_x, console_p, mem_rdata;
  logic [15:0] acc_a_r, acc_b_r, idx_x_r, pc_r, mem_addr_r, mem_wdata_r;
  logic [5:0]  indirect_depth;
  logic [3:0]  sense_sw;
  logic [1:0]  lat;
  exec_op_t    mem_op;
  int          error_cnt, compares, cyc;
  logic [31:0] tbl [13] = '{32'h0102_0810, 32'h0101_0a10, 32'h0102_0801, 32'h0102_0a02,
    32'h0102_0880, 32'h0101_0900, 32'h0101_0840, 32'h0102_0a20, 32'h0102_0800,
    32'h0101_0400, 32'h0003_0108, 32'h0003_01ff, 32'h0101_0107};
  arith_logic_exec u_dut (.*);
  core_mem_model u_mem (.ref_clk, .req(mem_req_r), .we(mem_we_r), .addr(mem_addr_r),
    .wdata(mem_wdata_r), .lat, .rdata(mem_rdata), .ack(mem_ack));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // A hang counts as a mismatch and closes the run.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ld(logic [15:0] a, logic [15:0] b, logic [15:0] x, logic [15:0] p);
    @(negedge ref_clk);
    {console_a, console_b, console_x, console_p} = {a, b, x, p};
    console_load = 1'b1;
    @(negedge ref_clk);
    console_load = 1'b0;
  endtask
  // Waits for ready again, or for a halt, under a bounded count.
  task automatic run(exec_op_t op, logic [15:0] w, logic [15:0] e);
    int n;
    @(negedge ref_clk);
    mem_op = op;
    {instr_word, eff_addr} = {w, e};
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    for (n = 0; n < 5000 && !ready_r && !halted_r; n++) @(negedge ref_clk);
  endtask
  task automatic lg(exec_op_t op, logic [15:0] d, logic [15:0] exp);
    u_mem.mem[11] = d;
    run(op, 16'h0000, 16'h000b);
    chk(32'(acc_a_r), 32'(exp));
  endtask
  task automatic sk(logic [15:0] w, logic [15:0] exp);
    ld(16'hfffd, 16'h0000, 16'hfffd, 16'h0100);
    run(OP_DECODE, w, 16'h0000);
    chk(32'(pc_r), 32'(exp));
  endtask
  initial begin
    {start, long_form, protect_fault, run_button, step_mode, int_pending, console_load} = '0;
    {instr_word, eff_addr, console_a, console_b, console_x, console_p} = '0;
    {indirect_depth, sense_sw, lat} = {6'h00, 4'h1, 2'h3};
    mem_op = OP_DECODE;
    rstn = 1'b0;
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    chk({acc_a_r, 14'h0000, ovf_r, ready_r}, 32'h0000_0001);
    ld(16'h0001, 16'h7fff, 16'h0005, 16'h0100);
    {u_mem.mem[8], u_mem.mem[9], u_mem.mem[10]} = {16'h0000, 16'h0001, 16'h7fff};
    run(OP_DOUBLE_ADD, 16'h0000, 16'h0008);
    chk({acc_a_r, acc_b_r}, 32'h0002_0000);
    run(OP_DOUBLE_SUBTRACT, 16'h0000, 16'h0008);
    chk({acc_a_r, acc_b_r}, 32'h0001_7fff);
    lat = 2'h0;
    run(OP_INC, 16'h0000, 16'h000a);
    chk(32'(u_mem.mem[10]), 32'h0000_8000);
    run(OP_DEC, 16'h0000, 16'h000a);
    chk({u_mem.mem[10], 15'h0000, ovf_r}, 32'h7fff_0000);
    long_form = 1'b1;
    lg(OP_XOR, 16'hf0f0, 16'hf0f1);
    long_form = 1'b0;
    lg(OP_AND, 16'h0ff1, 16'h00f1);
    lg(OP_OR, 16'h0f00, 16'h0ff1);
    run(OP_DECODE, 16'h049d, 16'h0000);
    chk(32'(acc_a_r), 32'h0000_0ff1);
    ld(16'h4000, 16'h0081, 16'h0000, 16'h0100);
    {u_mem.mem[8], u_mem.mem[9]} = 32'h0000_0000;
    run(OP_FLOAT_DIVIDE, 16'h0000, 16'h0008);
    chk({acc_a_r[14:0], acc_b_r, ovf_r}, {15'h7fff, 16'h7fff, 1'b1});
    ld(16'h0003, 16'h0000, 16'h0000, 16'h0100);
    run(OP_DECODE, 16'h049d, 16'h0000);
    chk({acc_a_r, idx_x_r}, 32'hfffd_fffd);
    foreach (tbl[i]) sk(tbl[i][15:0], tbl[i][31:16]);
    indirect_depth = 6'h20;
    run(OP_INC, 16'h0000, 16'h000a);
    chk({pc_r, u_mem.mem[10]}, 32'h0002_7fff);
    indirect_depth = 6'h00;
    int_pending = 1'b1;
    for (int f = 0; f < 2; f++) begin
      long_form = f[0];
      ld(16'h0000, 16'h0000, 16'h0000, 16'h0100);
      run(OP_CALL, 16'h0000, 16'h0014);
      chk({pc_r, u_mem.mem[20]}, 32'h0015_0101 + 32'(f));
      chk(32'(int_grant_r), 32'h0000_0000);
    end
    long_form = 1'b0;
    {u_mem.mem[8], u_mem.mem[9]} = 32'h0800_0080;
    run(OP_FLOAT_ADD, 16'h0000, 16'h0008);
    chk({acc_a_r, acc_b_r}, 32'h4000_007d);
    ld(16'h4000, 16'h0081, 16'h0000, 16'h0100);
    {u_mem.mem[8], u_mem.mem[9]} = 32'hc000_0081;
    run(OP_FLOAT_MULTIPLY, 16'h0000, 16'h0008);
    chk({acc_a_r, acc_b_r}, 32'h8000_0080);
    chk(32'(int_grant_r), 32'h0000_0001);
    ld(16'h0000, 16'h0000, 16'h0000, 16'h0100);
    run(OP_DECODE, 16'h0000, 16'h0000);
    chk(32'(halted_r), 32'h0000_0001);
    run_button = 1'b1;
    repeat (6) @(negedge ref_clk);
    run_button = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({15'h0000, halted_r, pc_r}, 32'h0000_0101);
    print_verdict();
  end
endmodule
`default_nettype wire
